// ### shared/agc_pkg.sv
package agc_pkg;

  // gain word layout
  localparam int          AGC_GAIN_W        = 7;
  localparam int          AGC_MAG_W         = 6;
  localparam int          AGC_SIGN_POS      = 6;
  localparam int          AGC_GAIN_SHIFT    = 12;   // one step is 1/4096
  localparam logic [6:0]  AGC_GAIN_RST      = 7'h00;
  localparam int          AGC_RES_W         = 12;

  // serial frame shape
  localparam logic [4:0]  AGC_WORD_LEN_FIELD = 5'h1E; // length minus one
  localparam int          AGC_FRAME_BITS    = 31;
  localparam int          AGC_EXTRA_BITS    = 14;
  localparam int          AGC_LONG_BITS     = 45;
  localparam int          AGC_IDLE_FALL     = 47;   // line released here
  localparam int          AGC_LEAD_ZEROS    = 19;
  localparam int          AGC_GAP_ZEROS     = 2;
  localparam int          AGC_CNT_W         = 6;

  // command word sent by the host on the command line
  localparam int          AGC_CMD_BITS      = 16;
  localparam int          AGC_CMD_WR_POS    = 15;
  localparam int          AGC_CMD_CH_POS    = 14;

  // receiver set-up of the host
  localparam logic        AGC_FALLING_EDGE_SAMPLE_SELECT = 1'b1;
  localparam logic        AGC_LOW_FRAME_POLARITY         = 1'b1;
  localparam logic        AGC_FRAME_EACH_WORD            = 1'b1;
  localparam logic        AGC_INTERNAL_FRAME_SOURCE      = 1'b1;
  localparam logic        AGC_BIT_ORDER_SELECT           = 1'b0; // msb first
  localparam logic [1:0]  AGC_FILL_TYPE                  = 2'h0; // zero fill
  localparam logic        AGC_INTERNAL_CLOCK_SOURCE      = 1'b1;

  // timing
  localparam int          AGC_REF_PERIOD_NS  = 8;
  localparam int          AGC_SCLK_PERIOD_NS = 80;
  localparam int          AGC_SCLK_HALF_CYC  =
    AGC_SCLK_PERIOD_NS / (2 * AGC_REF_PERIOD_NS);

  // host register map
  localparam logic [7:0]  AGC_REG_CTRL      = 8'h00;
  localparam logic [7:0]  AGC_REG_GAIN_CMD  = 8'h04;
  localparam logic [7:0]  AGC_REG_STATUS    = 8'h08;
  localparam logic [7:0]  AGC_REG_RES_A     = 8'h0C;
  localparam logic [7:0]  AGC_REG_RES_B     = 8'h10;
  localparam logic [7:0]  AGC_REG_RES_A2    = 8'h14;
  localparam logic [7:0]  AGC_REG_RES_B2    = 8'h18;
  localparam int          AGC_CTRL_START    = 0;
  localparam int          AGC_CTRL_LONG     = 1;
  localparam int          AGC_CTRL_RX_ON    = 2;
  localparam int          AGC_CTRL_LANE2    = 3;
  localparam int          AGC_GCMD_CH_POS   = 7;
  localparam int          AGC_STAT_BUSY     = 0;
  localparam int          AGC_STAT_DONE     = 1;
  localparam int          AGC_STAT_GPEND    = 2;

  typedef logic [6:0]         agc_gain_t;
  typedef logic signed [11:0] agc_res_t;

  typedef enum logic [1:0] {
    AGC_D_IDLE  = 2'b01,
    AGC_D_SHIFT = 2'b10
  } agc_dev_state_t;

  typedef enum logic [2:0] {
    AGC_H_IDLE = 3'b001,
    AGC_H_RUN  = 3'b010,
    AGC_H_END  = 3'b100
  } agc_host_state_t;

endpackage : agc_pkg

// ### shared/agc_link_if.sv
`timescale 1ns/1ps
interface agc_link_if;
  logic sclk;          // link clock made by the host
  logic frame_n;       // frame select, active low
  logic cmd;           // command line host to device
  logic line_a_drv;    // result_line_first driven value
  logic line_a_oe_n;   // low while device drives
  logic line_b_drv;    // result_line_second driven value
  logic line_b_oe_n;
  logic result_line_first;
  logic result_line_second;

  // released lines read as low
  assign result_line_first  = line_a_oe_n ? 1'b0 : line_a_drv;
  assign result_line_second = line_b_oe_n ? 1'b0 : line_b_drv;

  modport dev (
    input  sclk, frame_n, cmd,
    output line_a_drv, line_a_oe_n, line_b_drv, line_b_oe_n
  );
  modport host (
    output sclk, frame_n, cmd,
    input  result_line_first, result_line_second
  );
endinterface : agc_link_if

// ### verilog/agc_dev_end.sv
`timescale 1ns/1ps
module agc_dev_end
  import agc_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            arst_n_i,
  // link
  agc_link_if.dev              link,
  // sample stream from the converter core
  input  wire logic            sample_valid_i,
  output logic                 sample_ready_o,
  input  wire agc_pkg::agc_res_t sample_a_i,
  input  wire agc_pkg::agc_res_t sample_b_i,
  input  wire agc_pkg::agc_res_t offset_a_i,
  input  wire agc_pkg::agc_res_t offset_b_i,
  // gain visibility
  output agc_pkg::agc_gain_t   gain_a_o,
  output agc_pkg::agc_gain_t   gain_b_o
);
  import agc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // link input synchronisers, three stages, change when 2 and 3 agree
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] filt;
  logic [2:0] filt_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= 3'h3;
      s2 <= 3'h3;
      s3 <= 3'h3;
    end else begin
      s1 <= {link.cmd, link.frame_n, link.sclk};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // filtered levels and their previous values
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt   <= 3'h3;
      filt_q <= 3'h3;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
      end
      filt_q <= filt;
    end
  end

  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  assign sclk_fall   = filt_q[0] && !filt[0] && !filt[1];
  assign frame_start = filt_q[1] && !filt[1];
  assign frame_end   = !filt_q[1] && filt[1];

  ////////////////////////////////////////////////////////////////////////
  // two-entry sample buffer
  logic [2*AGC_RES_W-1:0] buf_mem [2];
  logic                   wr_ptr;
  logic                   rd_ptr;
  logic [1:0]             buf_cnt;
  logic                   push;
  logic                   pop;

  assign sample_ready_o = (buf_cnt != 2'h2);
  assign push = sample_valid_i && sample_ready_o;
  assign pop  = frame_start && (buf_cnt != 2'h0);

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      buf_mem[wr_ptr] <= {sample_a_i - offset_a_i, sample_b_i - offset_b_i};
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain scaling with saturation
  function automatic agc_res_t agc_scale(input agc_res_t s,
                                         input agc_gain_t g);
    logic signed [AGC_RES_W+AGC_MAG_W:0]      prod;
    logic signed [AGC_RES_W+AGC_GAIN_SHIFT:0] full;
    logic signed [AGC_RES_W+AGC_GAIN_SHIFT:0] q;
    logic signed [AGC_RES_W+AGC_GAIN_SHIFT:0] hi;
    logic signed [AGC_RES_W+AGC_GAIN_SHIFT:0] lo;
    prod = 19'(s) * 19'($signed({1'b0, g[AGC_MAG_W-1:0]}));
    full = {s[AGC_RES_W-1], s, {AGC_GAIN_SHIFT{1'b0}}};
    if (g[AGC_SIGN_POS]) begin
      full = full + 25'(prod);
    end else begin
      full = full - 25'(prod);
    end
    q  = full >>> AGC_GAIN_SHIFT;
    hi = 25'sh00007FF;
    lo = -25'sh0000800;
    if (q > hi) begin
      agc_scale = 12'sh7FF;
    end else if (q < lo) begin
      agc_scale = -12'sh800;
    end else begin
      agc_scale = q[AGC_RES_W-1:0];
    end
  endfunction : agc_scale

  ////////////////////////////////////////////////////////////////////////
  // gain registers, one per channel
  agc_gain_t          gain [2];
  logic [AGC_CMD_BITS-1:0] cmd_sr;
  logic [AGC_CNT_W-1:0]    fall_cnt;
  logic                    cmd_done;

  assign cmd_done = sclk_fall && (fall_cnt == 6'(AGC_CMD_BITS - 1));

  for (genvar ch = 0; ch < 2; ch++) begin : g_gain
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        gain[ch] <= AGC_GAIN_RST;
      end else if (cmd_done && cmd_sr[AGC_CMD_WR_POS-1]
                   && (cmd_sr[AGC_CMD_CH_POS-1] == 1'(ch))) begin
        gain[ch] <= {cmd_sr[AGC_GAIN_W-2:0], filt[2]};
      end
    end
  end

  assign gain_a_o = gain[0];
  assign gain_b_o = gain[1];

  ////////////////////////////////////////////////////////////////////////
  // frame state and output shifting
  agc_dev_state_t          state;
  logic [AGC_LONG_BITS-1:0] sr_a;
  logic [AGC_LONG_BITS-1:0] sr_b;
  agc_res_t                res_a;
  agc_res_t                res_b;
  logic [2*AGC_RES_W-1:0]  head;

  assign head = buf_mem[rd_ptr];
  // each channel through its own multiplier
  assign res_a = agc_scale(head[2*AGC_RES_W-1:AGC_RES_W], gain[0]);
  assign res_b = agc_scale(head[AGC_RES_W-1:0], gain[1]);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= AGC_D_IDLE;
      fall_cnt <= '0;
      sr_a     <= '0;
      sr_b     <= '0;
      cmd_sr   <= '0;
    end else begin
      case (state)
        AGC_D_IDLE: begin
          if (frame_start) begin
            state    <= AGC_D_SHIFT;
            fall_cnt <= '0;
            // other channel follows after two zeros
            if (pop) begin
              sr_a <= {{AGC_LEAD_ZEROS{1'b0}}, res_a,
                       {AGC_GAP_ZEROS{1'b0}}, res_b};
              sr_b <= {{AGC_LEAD_ZEROS{1'b0}}, res_b,
                       {AGC_GAP_ZEROS{1'b0}}, res_a};
            end else begin
              // no pair waiting: send zeros, not the last frame's tail
              sr_a <= '0;
              sr_b <= '0;
            end
          end
        end
        AGC_D_SHIFT: begin
          if (frame_end) begin
            state <= AGC_D_IDLE;
          end else if (sclk_fall) begin
            fall_cnt <= fall_cnt + 6'h01;
            sr_a     <= {sr_a[AGC_LONG_BITS-2:0], 1'b0};
            sr_b     <= {sr_b[AGC_LONG_BITS-2:0], 1'b0};
            if (fall_cnt < 6'(AGC_CMD_BITS)) begin
              cmd_sr <= {cmd_sr[AGC_CMD_BITS-2:0], filt[2]};
            end
          end
        end
        default: begin
          state <= AGC_D_IDLE;
        end
      endcase
    end
  end

  // lines driven in the frame until the 47th fall
  logic drive;
  assign drive = (state == AGC_D_SHIFT) && !filt[1]
                 && (fall_cnt < 6'(AGC_IDLE_FALL));

  // data straight from the shift flops; one more register would push
  // the round trip past one link clock period
  assign link.line_a_drv = sr_a[AGC_LONG_BITS-1];
  assign link.line_b_drv = sr_b[AGC_LONG_BITS-1];

  // enables registered, low while the lines are driven
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.line_a_oe_n <= 1'b1;
      link.line_b_oe_n <= 1'b1;
    end else begin
      link.line_a_oe_n <= !drive;
      link.line_b_oe_n <= !drive;
    end
  end

endmodule : agc_dev_end

// ### verilog/agc_host_end.sv
`timescale 1ns/1ps
module agc_host_end
  import agc_pkg::*;
#(
  parameter int HALF_CYC = agc_pkg::AGC_SCLK_HALF_CYC
)
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // link
  agc_link_if.host         link,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o
);
  import agc_pkg::*;

  // the result round trip takes nine cycles, so a period under ten fails
  if (HALF_CYC < 5 || HALF_CYC > 255) begin : g_half_check
    $error("HALF_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // result line synchronisers, three stages
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] rx_in;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1    <= 2'h0;
      s2    <= 2'h0;
      s3    <= 2'h0;
      rx_in <= 2'h0;
    end else begin
      s1 <= {link.result_line_second, link.result_line_first};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == s3[i]) begin
          rx_in[i] <= s3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic                    start_req;
  logic                    long_mode;
  logic                    receiver_on;
  logic                    second_lane_on;
  logic [7:0]              gcmd;
  logic                    gcmd_pend;
  logic                    done;
  logic                    launch;
  logic                    finish;
  agc_host_state_t         state;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_req      <= 1'b0;
      long_mode      <= 1'b0;
      receiver_on    <= 1'b0;
      second_lane_on <= 1'b0;
      gcmd           <= 8'h00;
      gcmd_pend      <= 1'b0;
      done           <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == AGC_REG_CTRL) begin
        long_mode      <= reg_wdata_i[AGC_CTRL_LONG];
        receiver_on    <= reg_wdata_i[AGC_CTRL_RX_ON];
        second_lane_on <= reg_wdata_i[AGC_CTRL_LANE2];
      end
      // request is taken at launch; a new write wins
      if (reg_wr_i && reg_addr_i == AGC_REG_CTRL
          && reg_wdata_i[AGC_CTRL_START]) begin
        start_req <= 1'b1;
      end else if (launch) begin
        start_req <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == AGC_REG_GAIN_CMD) begin
        gcmd      <= reg_wdata_i[7:0];
        gcmd_pend <= 1'b1;
      end else if (launch) begin
        gcmd_pend <= 1'b0;
      end
      // done set wins over the clearing status read
      if (finish) begin
        done <= 1'b1;
      end else if (reg_rd_i && reg_addr_i == AGC_REG_STATUS) begin
        done <= 1'b0;
      end
    end
  end

  assign launch = (state == AGC_H_IDLE) && start_req && receiver_on;

  ////////////////////////////////////////////////////////////////////////
  // clock divider, frame and shifting
  logic [7:0]               div;
  logic [AGC_CNT_W-1:0]     fall_cnt;
  logic [AGC_CNT_W-1:0]     total;
  logic [AGC_CMD_BITS-1:0]  tx_sr;
  logic [AGC_LONG_BITS-1:0] rx_a;
  logic [AGC_LONG_BITS-1:0] rx_b;
  logic                     tick;

  assign total = long_mode ? 6'(AGC_LONG_BITS)
                           : 6'({1'b0, AGC_WORD_LEN_FIELD} + 6'h01);
  assign tick   = (div == 8'(HALF_CYC - 1));
  assign finish = (state == AGC_H_END) && tick;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state        <= AGC_H_IDLE;
      div          <= 8'h00;
      fall_cnt     <= '0;
      tx_sr        <= '0;
      rx_a         <= '0;
      rx_b         <= '0;
      link.sclk    <= 1'b1;
      link.frame_n <= 1'b1;
      link.cmd     <= 1'b0;
    end else begin
      div <= (tick || state == AGC_H_IDLE) ? 8'h00 : div + 8'h01;
      case (state)
        AGC_H_IDLE: begin
          if (launch) begin
            // internal clock and low frame per word
            state        <= AGC_H_RUN;
            fall_cnt     <= '0;
            link.frame_n <= !AGC_LOW_FRAME_POLARITY;
            tx_sr        <= {gcmd_pend, gcmd[AGC_GCMD_CH_POS],
                             7'h00, gcmd[AGC_GAIN_W-1:0]};
            link.cmd     <= gcmd_pend;
          end
        end
        AGC_H_RUN: begin
          if (tick) begin
            link.sclk <= !link.sclk;
            if (link.sclk) begin
              // falling edge, both lanes, msb first
              fall_cnt <= fall_cnt + 6'h01;
              rx_a     <= {rx_a[AGC_LONG_BITS-2:0], rx_in[0]};
              rx_b     <= {rx_b[AGC_LONG_BITS-2:0],
                           rx_in[1] & second_lane_on};
            end else begin
              tx_sr    <= {tx_sr[AGC_CMD_BITS-2:0], 1'b0};
              link.cmd <= tx_sr[AGC_CMD_BITS-2];
              if (fall_cnt == total) begin
                state <= AGC_H_END;
              end
            end
          end
        end
        AGC_H_END: begin
          if (tick) begin
            link.frame_n <= 1'b1;
            state        <= AGC_H_IDLE;
          end
        end
        default: begin
          state <= AGC_H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe, zero filled
  logic [AGC_RES_W-1:0] word_a;
  logic [AGC_RES_W-1:0] word_b;
  assign word_a = long_mode ? rx_a[AGC_EXTRA_BITS+AGC_RES_W-1:AGC_EXTRA_BITS]
                            : rx_a[AGC_RES_W-1:0];
  assign word_b = long_mode ? rx_b[AGC_EXTRA_BITS+AGC_RES_W-1:AGC_EXTRA_BITS]
                            : rx_b[AGC_RES_W-1:0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        AGC_REG_CTRL:     reg_rdata_o <= {28'h0, second_lane_on,
                                          receiver_on, long_mode, start_req};
        AGC_REG_GAIN_CMD: reg_rdata_o <= {24'h0, gcmd};
        AGC_REG_STATUS:   reg_rdata_o <= {29'h0, gcmd_pend, done,
                                          state != AGC_H_IDLE};
        AGC_REG_RES_A:    reg_rdata_o <= {20'h0, word_a};
        AGC_REG_RES_B:    reg_rdata_o <= {20'h0, word_b};
        AGC_REG_RES_A2:   reg_rdata_o <= {20'h0, rx_a[AGC_RES_W-1:0]};
        AGC_REG_RES_B2:   reg_rdata_o <= {20'h0, rx_b[AGC_RES_W-1:0]};
        default:          reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule : agc_host_end

// ### test/agc_link_monitor.sv
`timescale 1ns/1ps
module agc_link_monitor #(
  parameter int HALF_CYC = 5
)(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // link signals
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic cmd,
  input wire logic line_a_oe_n,
  input wire logic line_b_oe_n,
  input wire logic result_line_first,
  input wire logic result_line_second
);
  logic       sclk_q;
  logic [5:0] n_fall;
  logic [7:0] lo_cnt;
  logic [3:0] idle_cnt;

  ////////////////////////////////////////////////////////////////////////
  // previous link clock level
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sclk_q <= 1'b1;
    else sclk_q <= sclk;
  end

  // falls seen since the frame opened, held after it closes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) n_fall <= 6'h00;
    else if ($fell(frame_n)) n_fall <= 6'h00;
    else if (!frame_n && sclk_q && !sclk) n_fall <= n_fall + 6'h01;
  end

  // low phase length, so a wrong divider shows up
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) lo_cnt <= 8'h00;
    else lo_cnt <= sclk ? 8'h00 : lo_cnt + 8'h01;
  end

  // idle time between frames
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) idle_cnt <= 4'h0;
    else if (!frame_n) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // both lines taken up shortly after the frame opens
  sequence s_take;
    ##[1:20] (!line_a_oe_n && !line_b_oe_n);
  endsequence
  // both lines let go shortly after the frame closes
  sequence s_release;
    ##[0:8] (line_a_oe_n && line_b_oe_n);
  endsequence

  sclk_idle_a: assert property (frame_n |-> sclk)
    else $error("link clock not high between frames");
  sclk_half_a: assert property ($rose(sclk) |-> lo_cnt == HALF_CYC)
    else $error("link clock low phase has wrong length");
  lead_zero_a: assert property ($fell(sclk) && !frame_n
    && n_fall < 6'h13 |-> !result_line_first && !result_line_second)
    else $error("leading bits not zero");
  gap_zero_a: assert property ($fell(sclk) && !frame_n
    && (n_fall == 6'h1F || n_fall == 6'h20)
    |-> !result_line_first && !result_line_second)
    else $error("gap bits not zero");
  frame_len_a: assert property ($rose(frame_n)
    |-> (n_fall == 6'h1F || n_fall == 6'h2D))
    else $error("frame closed after wrong fall count");
  frame_drive_a: assert property ($fell(frame_n) |-> s_take)
    else $error("lines not driven in frame");
  frame_release_a: assert property ($rose(frame_n) |-> s_release)
    else $error("lines not released after frame");
  idle_quiet_a: assert property (idle_cnt >= 4'h8
    |-> line_a_oe_n && line_b_oe_n)
    else $error("line driven while idle");
  cmd_steady_a: assert property ($fell(sclk) |-> $stable(cmd))
    else $error("command bit moved at sample edge");
endmodule : agc_link_monitor

// ### test/adc_gain_correction_bench.sv
`timescale 1ns/1ps
module adc_gain_correction_bench;
  import agc_pkg::*;
  logic        ref_clk      = 1'b0;
  logic        arst_n       = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [31:0] reg_wdata    = 32'h0;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic        rd_q         = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic [31:0] e_v;
  logic [31:0] m_v;
  logic        sample_valid = 1'b0;
  logic        sample_ready;
  agc_res_t    sample_a     = 12'h000;
  agc_res_t    sample_b     = 12'h000;
  agc_res_t    offset_a     = 12'h000;
  agc_res_t    offset_b     = 12'h000;
  agc_gain_t   gain_a;
  agc_gain_t   gain_b;
  agc_gain_t   ea           = AGC_GAIN_RST;
  agc_gain_t   eb           = AGC_GAIN_RST;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          n_mismatch   = 0;
  int          cmp_count    = 0;

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // the two ends facing each other, with the watcher beside the link
  agc_link_if link_if();
  agc_dev_end agc_dev_end_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .link(link_if),
    .sample_valid_i(sample_valid), .sample_ready_o(sample_ready),
    .sample_a_i(sample_a), .sample_b_i(sample_b),
    .offset_a_i(offset_a), .offset_b_i(offset_b),
    .gain_a_o(gain_a), .gain_b_o(gain_b));
  agc_host_end #(.HALF_CYC(AGC_SCLK_HALF_CYC)) agc_host_end_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .link(link_if),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  agc_link_monitor #(.HALF_CYC(AGC_SCLK_HALF_CYC)) agc_link_monitor_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .sclk(link_if.sclk),
    .frame_n(link_if.frame_n), .cmd(link_if.cmd),
    .line_a_oe_n(link_if.line_a_oe_n), .line_b_oe_n(link_if.line_b_oe_n),
    .result_line_first(link_if.result_line_first),
    .result_line_second(link_if.result_line_second));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic timeout(input string what);
    n_mismatch++;
    $display("BAD %0t wait ran out: %s", $time, what);
    give_verdict();
  endtask : timeout

  // read data stand one cycle after the strobe; compare with oldest note
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      rd_val = reg_rdata;
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      if (m_v != 32'h0) check(reg_rdata & m_v, e_v & m_v, "read data");
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : rd

  // one frame, then wait for done in status
  task automatic run_frame(input logic lng, input logic ln2);
    int i;
    wr(AGC_REG_CTRL, {28'h0, ln2, 1'b1, lng, 1'b1});
    for (i = 0; i < 400; i++) begin
      rd(AGC_REG_STATUS, 32'h0, 32'h0);
      if (rd_val[AGC_STAT_DONE] === 1'b1) break;
    end
    if (i == 400) timeout("frame done");
    repeat (8) @(posedge ref_clk);
  endtask : run_frame

  // gain word sent on the command line, seen on the gain outputs
  task automatic set_gain(input logic ch, input agc_gain_t g);
    wr(AGC_REG_GAIN_CMD, {24'h0, ch, g});
    run_frame(1'b0, 1'b1);
    if (ch) eb = g;
    else ea = g;
    check({25'h0, gain_a}, {25'h0, ea}, "gain a");
    check({25'h0, gain_b}, {25'h0, eb}, "gain b");
  endtask : set_gain

  task automatic push(input int xa, input int xb, input int oa,
                      input int ob);
    int i;
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sample_a     <= xa[11:0];
    sample_b     <= xb[11:0];
    offset_a     <= oa[11:0];
    offset_b     <= ob[11:0];
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (sample_ready === 1'b1) break;
    end
    sample_valid <= 1'b0;
    if (i == 20) timeout("sample ready");
  endtask : push

  // corrected code: offset off, multiply by 1 +/- mag/4096, saturate
  function automatic logic [31:0] scale(input int x, input int off,
                                        input agc_gain_t g);
    int d;
    int k;
    k = 1 << AGC_GAIN_SHIFT;
    k = g[AGC_SIGN_POS] ? k + int'(g[5:0]) : k - int'(g[5:0]);
    d = ((x - off) * k) >>> AGC_GAIN_SHIFT;
    if (d > 2047) d = 2047;
    if (d < -2048) d = -2048;
    return {20'h0, d[11:0]};
  endfunction : scale

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int t;
    int xa;
    int xb;
    int oa;
    int ob;
    agc_gain_t ga;
    agc_gain_t gb;
    logic lng;
    logic ln2;
    void'($urandom(32'hEC0E5B0E));
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({25'h0, gain_a}, {25'h0, AGC_GAIN_RST}, "gain a reset");
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    for (t = 0; t < 6; t++) begin
      case (t)
        0: ga = 7'h3F;
        1: ga = 7'h00;
        2, 5: ga = 7'h7F;
        default: ga = 7'($urandom);
      endcase
      gb = (t == 5) ? 7'h7F : 7'($urandom);
      lng = t[0];
      ln2 = (t != 4);
      set_gain(1'b0, ga);
      set_gain(1'b1, gb);
      xa = int'($urandom_range(3600)) - 1800;
      xb = int'($urandom_range(3600)) - 1800;
      oa = int'($urandom_range(100)) - 50;
      ob = int'($urandom_range(100)) - 50;
      if (t == 5) begin
        xa = 2047;
        xb = -2048;
        oa = 0;
        ob = 0;
      end
      push(xa, xb, oa, ob);
      run_frame(lng, ln2);
      rd(AGC_REG_RES_A, scale(xa, oa, ga), 32'hFFFFFFFF);
      rd(AGC_REG_RES_B, ln2 ? scale(xb, ob, gb) : 32'h0, 32'hFFFFFFFF);
      if (lng) begin
        rd(AGC_REG_RES_A2, scale(xb, ob, gb), 32'hFFFFFFFF);
        rd(AGC_REG_RES_B2, ln2 ? scale(xa, oa, ga) : 32'h0, 32'hFFFFFFFF);
      end
      $display("test %0d done", t);
    end
    give_verdict();
  end
endmodule : adc_gain_correction_bench
